/* File: logic/flash_prog_map.svh */
// Offsets, field positions, command codes and strobe timings in ns of the flash program controller.
`ifndef FLASH_PROG_MAP_SVH
`define FLASH_PROG_MAP_SVH
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_DATA 12'h008
`define REG_STAT 12'h00C
`define REG_BASE 12'h010
`define CTRL_START_BIT 0
`define CTRL_MODE_LSB 1
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ABORT_BIT 2
`define STAT_TOUT_BIT 3
`define STAT_NEED_BIT 4
`define STAT_CNT_LSB 8
`define UNLOCK1_OFS 26'h0000555
`define UNLOCK2_OFS 26'h00002AA
`define UNLOCK1_DAT 16'h00AA
`define UNLOCK2_DAT 16'h0055
`define PROG_DAT 16'h00A0
`define BUFLOAD_DAT 16'h0025
`define CONFIRM_DAT 16'h0029
`define ABTRST_DAT 16'h00F0
`define BUF_WORDS 32
`define PAGE_LSB 5
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define TOUT_BIT 5
`define ABORT_BIT 1
`define WE_LOW_NS 40
`define WE_HIGH_NS 30
`define CLK_NS 10
`endif

/* File: logic/flash_prog_pkg.sv */
// Types of the flash program controller.
package flash_prog_pkg;
  typedef enum logic [1:0] {MODE_WORD, MODE_BUFFER, MODE_ABORT_RESET, MODE_READ} mode_e;
  typedef struct packed {
    logic [25:0] addr;
    logic [15:0] data;
    logic we;
  } bus_req_s;
endpackage : flash_prog_pkg

/* File: logic/flash_bus_cycle.sv */
// One asynchronous flash bus cycle: write strobe or read with output enable.
`timescale 1ns/1ps
`include "flash_prog_map.svh"
module flash_bus_cycle
  import flash_prog_pkg::*;
#(
  parameter int LOW_CYC = (`WE_LOW_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int HIGH_CYC = (`WE_HIGH_NS + `CLK_NS - 1) / `CLK_NS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Request
  input wire logic req,
  input wire bus_req_s req_s,
  output logic done,
  output logic [15:0] rdata,
  // Flash pins
  output logic [25:0] f_addr,
  output logic [15:0] f_dq_o,
  output logic f_dq_oe,
  input wire logic [15:0] f_dq_i,
  output logic f_ce_n,
  output logic f_we_n,
  output logic f_oe_n
);
  initial
  begin
    if (LOW_CYC < 1 || HIGH_CYC < 1 || LOW_CYC > 255 || HIGH_CYC > 255)
      $error("flash_bus_cycle: strobe counts out of range");
  end
  logic [7:0] cnt_q;
  logic act_q;
  logic hi_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      act_q <= 1'b0;
      hi_q <= 1'b0;
      cnt_q <= 8'h00;
      done <= 1'b0;
      rdata <= 16'h0000;
      f_addr <= 26'h0000000;
      f_dq_o <= 16'h0000;
      f_dq_oe <= 1'b0;
      f_ce_n <= 1'b1;
      f_we_n <= 1'b1;
      f_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (!act_q && req)
      begin
        // Address is set with both strobes falling together; data lands on the rising edge.
        act_q <= 1'b1;
        hi_q <= 1'b0;
        cnt_q <= LOW_CYC[7:0];
        f_addr <= req_s.addr;
        f_dq_o <= req_s.data;
        f_dq_oe <= req_s.we;
        f_ce_n <= 1'b0;
        f_we_n <= !req_s.we;
        f_oe_n <= req_s.we;
      end
      else if (act_q)
      begin
        if (cnt_q > 8'h01)
          cnt_q <= cnt_q - 8'h01;
        else if (!hi_q)
        begin
          hi_q <= 1'b1;
          cnt_q <= HIGH_CYC[7:0];
          rdata <= f_dq_i;
          f_ce_n <= 1'b1;
          f_we_n <= 1'b1;
          f_oe_n <= 1'b1;
        end
        else
        begin
          act_q <= 1'b0;
          f_dq_oe <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : flash_bus_cycle

/* File: logic/flash_prog_ctrl.sv */
// Host controller issuing word, buffer and abort-reset program sequences to a NOR flash.
//
// Summary of operation
// - Word program: two unlocks, A0, data
// - Buffer start: unlocks then 25 at sector
// - Count minus one written at sector
// - All pairs share page bits A5 and above
// - Confirm 29 at sector after loads
// - Abort reset: unlocks then F0
// - Poll status at last loaded address
// - Buffer sequence spans 6 to 37 writes
// - Prefer full buffers for several words
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "flash_prog_map.svh"
module flash_prog_ctrl
  import flash_prog_pkg::*;
#(
  parameter int BUF_WORDS = `BUF_WORDS,
  parameter int POLL_LIMIT = 100000
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Flash pins
  output logic [25:0] f_addr,
  output logic [15:0] f_dq_o,
  output logic f_dq_oe,
  input wire logic [15:0] f_dq_i,
  output logic f_ce_n,
  output logic f_we_n,
  output logic f_oe_n,
  output logic f_reset_n
);
  initial
  begin
    if (BUF_WORDS < 1 || BUF_WORDS > `BUF_WORDS || POLL_LIMIT < 2)
      $error("flash_prog_ctrl: parameter out of range");
  end
  typedef enum logic [3:0] {S_IDLE, S_UNLK1, S_UNLK2, S_CMD, S_COUNT, S_WAIT_DATA, S_LOAD,
    S_CONFIRM, S_POLL, S_FINISH} state_e;
  function automatic logic [1:0] ofs_ok(input logic [11:0] a);
    ofs_ok = (a[1:0] == 2'b00 && a <= `REG_BASE) ? 2'b00 : 2'b10;
  endfunction : ofs_ok
  state_e st_q;
  mode_e mode_q;
  logic [25:0] base_q, addr_q, last_q;
  logic [15:0] data_q, prev_q;
  logic data_full_q, start_q, busy_q, done_q, abort_q, tout_q;
  logic [5:0] cnt_q, left_q;
  logic [31:0] poll_q;
  logic aw_held_q, w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic breq, bdone;
  bus_req_s bs;
  logic [15:0] brd;
  // ------------------------------------------------------------
  // Register write channel
  // ------------------------------------------------------------
  logic wr_go;
  assign wr_go = aw_held_q && w_held_q && !s_bvalid;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'b00;
    end
    else if (ce)
    begin
      if (s_awvalid && s_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= ofs_ok(awaddr_q);
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end
  // Software-owned registers; the data word arms one word or buffer load.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      base_q <= 26'h0000000;
      addr_q <= 26'h0000000;
      data_q <= 16'h0000;
      mode_q <= MODE_WORD;
      cnt_q <= 6'h00;
      start_q <= 1'b0;
      data_full_q <= 1'b0;
    end
    else if (ce)
    begin
      start_q <= 1'b0;
      if (st_q == S_LOAD && bdone)
        data_full_q <= 1'b0;
      if (wr_go && wstrb_q == 4'hF)
      begin
        case (awaddr_q)
          `REG_CTRL:
          begin
            start_q <= wdata_q[`CTRL_START_BIT] && !busy_q;
            mode_q <= mode_e'(wdata_q[`CTRL_MODE_LSB +: 2]);
            cnt_q <= wdata_q[`STAT_CNT_LSB +: 6];
          end
          `REG_ADDR: addr_q <= wdata_q[25:0];
          `REG_DATA:
          begin
            data_q <= wdata_q[15:0];
            data_full_q <= 1'b1;
          end
          `REG_BASE: base_q <= wdata_q[25:0];
          default: ;
        endcase
      end
    end
  end
  // ------------------------------------------------------------
  // Register read channel
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= 2'b00;
    end
    else if (ce)
    begin
      if (s_arvalid && s_arready)
      begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rresp <= ofs_ok(s_araddr);
        case (s_araddr)
          `REG_CTRL: s_rdata <= {18'h0, cnt_q, 5'h0, mode_q, 1'b0};
          `REG_ADDR: s_rdata <= {6'h0, addr_q};
          `REG_DATA: s_rdata <= {16'h0, prev_q};
          `REG_STAT: s_rdata <= {18'h0, left_q, 3'h0, data_full_q, tout_q, abort_q,
            done_q, busy_q};
          `REG_BASE: s_rdata <= {6'h0, base_q};
          default: s_rdata <= 32'h00000000;
        endcase
      end
      if (s_rvalid && s_rready)
      begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    bs.we = 1'b1;
    bs.addr = base_q + `UNLOCK1_OFS;
    bs.data = `UNLOCK1_DAT;
    breq = 1'b0;
    case (st_q)
      S_UNLK1: breq = 1'b1;
      S_UNLK2:
      begin
        breq = 1'b1;
        bs.addr = base_q + `UNLOCK2_OFS;
        bs.data = `UNLOCK2_DAT;
      end
      S_CMD:
      begin
        breq = 1'b1;
        case (mode_q)
          MODE_WORD: bs.data = `PROG_DAT;
          MODE_BUFFER:
          begin
            bs.addr = addr_q;
            bs.data = `BUFLOAD_DAT;
          end
          default: bs.data = `ABTRST_DAT;
        endcase
      end
      S_COUNT:
      begin
        breq = 1'b1;
        bs.addr = addr_q;
        bs.data = {10'h000, cnt_q};
      end
      S_LOAD:
      begin
        breq = 1'b1;
        bs.addr = (mode_q == MODE_BUFFER) ? {last_q[25:`PAGE_LSB], addr_q[`PAGE_LSB-1:0]}
          : addr_q;
        bs.data = data_q;
      end
      S_CONFIRM:
      begin
        breq = 1'b1;
        bs.addr = last_q;
        bs.data = `CONFIRM_DAT;
      end
      S_POLL:
      begin
        breq = 1'b1;
        bs.we = 1'b0;
        bs.addr = last_q;
      end
      default: breq = 1'b0;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= S_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      tout_q <= 1'b0;
      left_q <= 6'h00;
      last_q <= 26'h0000000;
      prev_q <= 16'h0000;
      poll_q <= 32'h00000000;
      f_reset_n <= 1'b0;
    end
    else if (ce)
    begin
      f_reset_n <= 1'b1;
      case (st_q)
        S_IDLE:
          if (start_q && mode_q != MODE_READ && !(mode_q == MODE_BUFFER &&
            {26'h0, cnt_q} >= BUF_WORDS))
          begin
            st_q <= S_UNLK1;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            abort_q <= 1'b0;
            tout_q <= 1'b0;
            left_q <= cnt_q;
            last_q <= addr_q;
          end
        S_UNLK1: if (bdone) st_q <= S_UNLK2;
        S_UNLK2: if (bdone) st_q <= S_CMD;
        S_CMD:
          if (bdone)
          begin
            case (mode_q)
              MODE_WORD: st_q <= S_WAIT_DATA;
              MODE_BUFFER: st_q <= S_COUNT;
              default: st_q <= S_FINISH;
            endcase
          end
        S_COUNT: if (bdone) st_q <= S_WAIT_DATA;
        S_WAIT_DATA: if (data_full_q) st_q <= S_LOAD;
        S_LOAD:
          if (bdone)
          begin
            last_q <= bs.addr;
            prev_q <= data_q;
            poll_q <= 32'h00000000;
            if (mode_q != MODE_BUFFER)
              st_q <= S_POLL;
            else if (left_q == 6'h00)
              st_q <= S_CONFIRM;
            else
            begin
              left_q <= left_q - 6'h01;
              st_q <= S_WAIT_DATA;
            end
          end
        S_CONFIRM: if (bdone) st_q <= S_POLL;
        S_POLL:
          if (bdone)
          begin
            poll_q <= poll_q + 32'h00000001;
            if (brd[`POLL_BIT] == prev_q[`POLL_BIT])
              st_q <= S_FINISH;
            else if (brd[`ABORT_BIT])
            begin
              abort_q <= 1'b1;
              st_q <= S_FINISH;
            end
            else if (brd[`TOUT_BIT] || poll_q >= POLL_LIMIT)
            begin
              tout_q <= 1'b1;
              st_q <= S_FINISH;
            end
          end
        S_FINISH:
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Bus cycle engine
  // ------------------------------------------------------------
  flash_bus_cycle u_cyc (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .req(breq && !bdone),
    .req_s(bs),
    .done(bdone),
    .rdata(brd),
    .f_addr(f_addr),
    .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe),
    .f_dq_i(f_dq_i),
    .f_ce_n(f_ce_n),
    .f_we_n(f_we_n),
    .f_oe_n(f_oe_n)
  );
endmodule : flash_prog_ctrl

/* File: dv/flash_prog_checker.sv */
// Port assertions for the flash program controller.
`timescale 1ns/1ps
module flash_prog_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  // Flash
  input wire logic [25:0] f_addr,
  input wire logic [15:0] f_dq_o,
  input wire logic f_dq_oe,
  input wire logic f_ce_n,
  input wire logic f_we_n,
  input wire logic f_oe_n,
  input wire logic f_reset_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_write_frame: assert property (!f_we_n |-> !f_ce_n && f_oe_n && f_dq_oe)
    else $error("bad write frame");
  a_strobe_low: assert property ($fell(f_we_n) |-> !f_we_n [*4] ##1 f_we_n)
    else $error("bad strobe length");
  a_strobe_gap: assert property ($rose(f_we_n) |-> f_we_n [*3])
    else $error("short strobe gap");
  a_write_held: assert property (!f_we_n && $past(!f_we_n) |-> $stable(f_addr) && $stable(f_dq_o))
    else $error("write changed under strobe");
  a_read_frame: assert property (!f_oe_n |-> !f_ce_n && f_we_n && !f_dq_oe)
    else $error("bad read frame");
  a_pin_release: assert property ($fell(rst) |-> !f_reset_n ##[1:2] f_reset_n)
    else $error("flash reset pin wrong");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("late read answer");
  a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid)
    else $error("rvalid dropped");
  a_resp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("bvalid dropped");
  c_write: cover property ($fell(f_we_n));
  c_read: cover property ($fell(f_oe_n));
  c_resp: cover property (s_bvalid && s_bready);
endmodule : flash_prog_checker
bind flash_prog_ctrl flash_prog_checker chk (.*);

/* File: dv/flash_model.sv */
// Behavioural flash device answering program sequences.
`timescale 1ns/1ps
module flash_model
#(
  parameter logic [25:0] BASE = 26'h0000000,
  parameter int BUSY_READS = 3
)
(
  // Flash pins
  input wire logic [25:0] f_addr,
  input wire logic [15:0] f_dq_o,
  output logic [15:0] f_dq_i,
  input wire logic f_ce_n,
  input wire logic f_we_n,
  input wire logic f_oe_n,
  input wire logic f_reset_n,
  // Abort injection
  input wire logic inj
);
  logic [15:0] mem [int];
  logic [15:0] pend [int];
  logic [25:0] la, sect, last_a;
  logic [15:0] last_d, d;
  logic [15:0] rd_q = 16'h0000;
  logic armed = 1'b0;
  logic abt = 1'b0;
  logic abrst_seen = 1'b0;
  logic tog = 1'b0;
  int st, left, busy, wcnt, extra;
  wire wr_n = f_we_n | f_ce_n;
  wire rd_n = f_oe_n | f_ce_n;
  assign f_dq_i = (rd_n === 1'b0) ? rd_q : ~rd_q;
  function automatic logic [15:0] peek(input logic [25:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : peek
  always @(negedge wr_n)
  begin
    la = f_addr;
    armed = 1'b1;
  end
  always @(posedge wr_n)
  begin
    if (armed && st != 7)
    begin
      d = f_dq_o;
      wcnt++;
      case (st)
        0: st = (la == BASE + 26'h555 && d == 16'h00AA) ? 1 : 0;
        1: st = (la == BASE + 26'h2AA && d == 16'h0055) ? 2 : 0;
        2:
        begin
          st = (la == BASE + 26'h555 && d == 16'h00A0) ? 3 : (d == 16'h0025) ? 4 : 0;
          sect = la;
          abrst_seen = abt && la == BASE + 26'h555 && d == 16'h00F0;
          abt = abt && !abrst_seen;
        end
        3:
        begin
          mem[la] = peek(la) & d;
          last_d = d;
          busy = BUSY_READS + extra;
          st = 7;
        end
        4:
        begin
          left = d + 1;
          abt = la[25:16] != sect[25:16] || d >= 16'd32;
          st = abt ? 0 : 5;
          pend.delete();
        end
        5:
        begin
          if (pend.num() == 0)
            last_a = la;
          abt = la[25:16] != sect[25:16] || la[25:5] != last_a[25:5];
          pend[la] = d;
          last_d = d;
          left--;
          st = abt ? 0 : (left == 0) ? 6 : 5;
        end
        6:
        begin
          abt = !(la[25:16] == sect[25:16] && d == 16'h0029 && !inj);
          st = abt ? 0 : 7;
          busy = abt ? 0 : BUSY_READS;
          if (!abt)
            foreach (pend[k])
              mem[k] = peek(26'(k)) & pend[k];
        end
        default: st = 0;
      endcase
    end
    armed = 1'b0;
  end
  always @(negedge rd_n)
  begin
    tog = ~tog;
    rd_q = peek(f_addr);
    if (abt || busy > 0)
      rd_q = {8'h00, ~last_d[7], tog, 3'b000, tog, abt, 1'b0};
    if (busy > 0)
      busy--;
    if (busy == 0 && st == 7)
      st = 0;
  end
  always @(negedge f_reset_n)
  begin
    st = 0;
    busy = 0;
    abt = 1'b0;
  end
endmodule : flash_model

/* File: dv/testbench.sv */
// Testbench for the flash program controller against a device model.
`timescale 1ns/1ps
`include "flash_prog_map.svh"
module testbench;
  import flash_prog_pkg::*;
  localparam logic [25:0] BASE_A = 26'h0100000;
  logic clk, rst, ce, inj;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, v;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, r;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [25:0] f_addr;
  logic [15:0] f_dq_o, f_dq_i;
  logic f_dq_oe, f_ce_n, f_we_n, f_oe_n, f_reset_n;
  int bad_count, n_compared, cyc;
  flash_prog_ctrl #(.POLL_LIMIT(20)) uut (.*);
  flash_model #(.BASE(BASE_A)) fm (.f_addr(f_addr), .f_dq_o(f_dq_o), .f_dq_i(f_dq_i),
    .f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_reset_n(f_reset_n), .inj(inj));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic axi_write(input logic [11:0] a, input logic [31:0] dat);
    logic got;
    got = 1'b0;
    s_awaddr <= a;
    s_wdata <= dat;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!got)
    begin
      @(posedge clk);
      if (s_awvalid && s_awready)
        s_awvalid <= 1'b0;
      if (s_wvalid && s_wready)
        s_wvalid <= 1'b0;
      got = s_bvalid;
    end
    // Ready is raised only after the answer, so the slave must hold it meanwhile.
    s_bready <= 1'b1;
    @(posedge clk);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [11:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_arvalid && s_arready)
        s_arvalid <= 1'b0;
    end
    while (s_rvalid !== 1'b1);
    s_rready <= 1'b1;
    @(posedge clk);
    v = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : axi_read
  task automatic wait_clear(input int b);
    int k;
    k = 0;
    do
    begin
      axi_read(`REG_STAT);
      k++;
    end
    while (v[b] === 1'b1 && k < 500);
    check("wait clear", 0, v[b]);
  endtask : wait_clear
  function automatic logic [31:0] ctrl(input mode_e m, input logic [5:0] c);
    return {18'h0, c, 5'h0, m, 1'b1};
  endfunction : ctrl
  task automatic buf_prog(input logic [25:0] a[$], input logic [15:0] dat[$]);
    fm.wcnt = 0;
    axi_write(`REG_ADDR, {6'h0, a[0]});
    axi_write(`REG_CTRL, ctrl(MODE_BUFFER, 6'(a.size() - 1)));
    foreach (a[i])
    begin
      axi_write(`REG_ADDR, {6'h0, a[i]});
      axi_write(`REG_DATA, {16'h0, dat[i]});
      wait_clear(`STAT_NEED_BIT);
    end
    wait_clear(`STAT_BUSY_BIT);
  endtask : buf_prog
  initial
  begin
    {rst, ce, inj, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= 8'hC0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} <= {24'h0, 32'h0, 4'hF};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_read(`REG_STAT);
    check("stat reset", 0, v);
    axi_read(12'h020);
    check("unmapped read resp", 2, r);
    axi_write(12'h024, 32'h1);
    check("unmapped write resp", 2, r);
    axi_write(`REG_BASE, {6'h0, BASE_A});
    axi_read(`REG_BASE);
    check("base", {6'h0, BASE_A}, v);
    s_wstrb <= 4'h3;
    axi_write(`REG_BASE, 32'h0);
    s_wstrb <= 4'hF;
    axi_read(`REG_BASE);
    check("partial write ignored", {6'h0, BASE_A}, v);
    $display("test registers done");
    fm.wcnt = 0;
    axi_write(`REG_ADDR, 32'h0012345);
    axi_write(`REG_DATA, 32'h5A3C);
    axi_write(`REG_CTRL, ctrl(MODE_WORD, 6'h0));
    wait_clear(`STAT_BUSY_BIT);
    check("word status", 4'h2, v[3:0]);
    check("word data", 16'h5A3C, fm.peek(26'h0012345));
    check("word cycles", 4, fm.wcnt);
    $display("test word done");
    buf_prog('{26'h0230041, 26'h0230042, 26'h0230041, 26'h0230043},
      '{16'h1111, 16'h2222, 16'h3333, 16'h4444});
    check("buffer status", 4'h2, v[3:0]);
    check("repeat load", 16'h3333, fm.peek(26'h0230041));
    check("other load", 16'h4444, fm.peek(26'h0230043));
    check("buffer cycles", 9, fm.wcnt);
    buf_prog('{26'h0230042}, '{16'h0F0F});
    check("reprogram", 16'h0202, fm.peek(26'h0230042));
    check("short cycles", 6, fm.wcnt);
    $display("test buffer done");
    inj <= 1'b1;
    buf_prog('{26'h0230050}, '{16'h1234});
    check("abort flag", 1, v[`STAT_ABORT_BIT]);
    inj <= 1'b0;
    fm.wcnt = 0;
    axi_write(`REG_CTRL, ctrl(MODE_ABORT_RESET, 6'h0));
    wait_clear(`STAT_BUSY_BIT);
    check("abort reset seen", 1, fm.abrst_seen);
    check("abort reset cycles", 3, fm.wcnt);
    $display("test abort done");
    fm.wcnt = 0;
    axi_write(`REG_CTRL, ctrl(MODE_BUFFER, 6'd32));
    axi_read(`REG_STAT);
    check("oversize busy", 0, v[`STAT_BUSY_BIT]);
    check("oversize cycles", 0, fm.wcnt);
    axi_write(`REG_CTRL, ctrl(MODE_READ, 6'h0));
    axi_read(`REG_STAT);
    check("read mode busy", 0, v[`STAT_BUSY_BIT]);
    $display("test oversize done");
    // The model stays busy past the poll limit, so the run must end in a timeout.
    fm.extra = 30;
    axi_write(`REG_ADDR, 32'h0012400);
    axi_write(`REG_DATA, 32'h0011);
    axi_write(`REG_CTRL, ctrl(MODE_WORD, 6'h0));
    wait_clear(`STAT_BUSY_BIT);
    check("timeout status", 4'hA, v[3:0]);
    $display("test timeout done");
    tally_and_finish;
  end
endmodule : testbench
